// ### src/maca_consts.svh
// register indices, field positions and reset values of the accumulator access block
`ifndef MACA_CONSTS_SVH
`define MACA_CONSTS_SVH
`define MACA_IDX_AC0 8'he8
`define MACA_IDX_AC1 8'he9
`define MACA_IDX_AC2 8'hea
`define MACA_IDX_AC3 8'heb
`define MACA_IDX_AC4 8'hec
`define MACA_IDX_STAT 8'hed
`define MACA_IDX_CFG 8'hee
`define MACA_IDX_IRQST 8'hf0
`define MACA_IDX_IRQMSK 8'hf1
`define MACA_CFG_IN_LSB 0
`define MACA_CFG_OUT_LSB 3
`define MACA_CFG_FILL_BIT 6
`define MACA_STAT_BANK_BIT 4
`define MACA_STAT_COMPUTE_BANK_LSB 2
`define MACA_STAT_DATA_LSB 0
`define MACA_IRQ_DONE_BIT 0
`define MACA_IRQ_SWAP_BIT 1
`define MACA_CFG_RESET 8'h00
`define MACA_IRQ_RESET 2'h0
`endif

// ### src/maca_pkg.sv
// types shared by the accumulator access block
package maca_pkg;
  typedef enum logic [1:0] {
    DS_EMPTY = 2'h0,
    DS_READY = 2'h1,
    DS_DONE = 2'h3
  } maca_dstat_t;
  typedef enum logic [1:0] {
    CS_EMPTY = 2'h0,
    CS_BUSY = 2'h2,
    CS_DONE = 2'h3
  } maca_cstat_t;
  typedef logic [39:0] maca_acc_t;
endpackage

// ### src/maca_access.sv
// cpu access to the 40-bit two-bank accumulator over apb
//
// Summary of operation
// - byte register 0xe8 holds accumulator bits 7:0 of the 40-bit accumulator.
// - byte register 0xe9 holds accumulator bits 15:8, read and write.
// - byte register 0xea holds accumulator bits 23:16, read and write.
// - byte register 0xeb holds accumulator bits 31:24, read and write.
// - byte register 0xec holds accumulator bits 39:32, read and write.
// - reading the top byte empties the data bank.
// - reading the top byte with a finished compute bank swaps banks, leaving data done and compute empty.
// - writing the top byte moves the data bank from empty to ready.
// - after that write, if the compute bank is empty and the engine can accept work, banks swap and the compute bank goes in progress.
// - data bank status codes are 00 empty, 01 ready, 11 done, 10 never used.
// - reads return the accumulator arithmetically shifted right by 0 to 7 bits, sign filled from bit 39.
// - writes are shifted left by 0 to 7 bits, the low bits filled with the fill bit.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "maca_consts.svh"

module maca_access (
  input wire logic mclk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic cen, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic engIdle, // engine can accept a calculation
  input wire logic engDone, // engine finished, pulse
  input wire maca_pkg::maca_acc_t engResult, // result with engDone
  output maca_pkg::maca_acc_t calcAcc, // compute bank contents
  output logic engStart, // start pulse
  output logic irq // interrupt level
);
  import maca_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic [2:0] accSlot(input logic [9:0] idx);
    case (idx)
      {2'h0, `MACA_IDX_AC0}: accSlot = 3'h0;
      {2'h0, `MACA_IDX_AC1}: accSlot = 3'h1;
      {2'h0, `MACA_IDX_AC2}: accSlot = 3'h2;
      {2'h0, `MACA_IDX_AC3}: accSlot = 3'h3;
      {2'h0, `MACA_IDX_AC4}: accSlot = 3'h4;
      default: accSlot = 3'h7;
    endcase
  endfunction

  wire logic [9:0] regIdx = paddr[11:2];
  wire logic [2:0] slot = accSlot(regIdx);
  wire logic isAcc = (slot != 3'h7);
  wire logic isStat = (regIdx == {2'h0, `MACA_IDX_STAT});
  wire logic isCfg = (regIdx == {2'h0, `MACA_IDX_CFG});
  wire logic isIst = (regIdx == {2'h0, `MACA_IDX_IRQST});
  wire logic isMsk = (regIdx == {2'h0, `MACA_IDX_IRQMSK});
  wire logic mapped = isAcc | isStat | isCfg | isIst | isMsk;
  wire logic setup = cen & psel & ~penable;
  wire logic access = cen & psel & penable;
  wire logic wrAcc = access & pwrite & isAcc;
  wire logic rdAc4 = access & ~pwrite & (slot == 3'h4);
  wire logic wrAc4 = wrAcc & (slot == 3'h4);

  assign pready = cen;
  assign pslverr = psel & penable & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic bank_r;
  maca_dstat_t dataStat_r;
  maca_cstat_t calcStat_r;
  logic engStart_r;
  logic [7:0] cfg_r;
  logic [1:0] ist_r;
  logic [1:0] msk_r;
  logic [31:0] prdata_r;
  maca_acc_t acc_r [2];
  maca_acc_t wrImg_r;

  logic bank_nxt;
  maca_dstat_t dataStat_nxt;
  maca_cstat_t calcStat_nxt;
  logic startNow;
  logic swapNow;

  wire logic [2:0] inShift = cfg_r[`MACA_CFG_IN_LSB +: 3];
  wire logic [2:0] outShift = cfg_r[`MACA_CFG_OUT_LSB +: 3];
  wire logic fillBit = cfg_r[`MACA_CFG_FILL_BIT];

  // the byte registers always see the current data bank
  wire maca_acc_t dataAcc = acc_r[bank_r];
  assign calcAcc = acc_r[~bank_r];

  ////////////////////////////////////////////////////////////////////////////
  // read path: arithmetic shift right, sign from bit 39
  wire maca_acc_t rdView = maca_acc_t'($signed(dataAcc) >>> outShift);
  wire logic [7:0] rdByte = rdView[slot[1:0] * 8 +: 8] & {8{slot != 3'h4}}
    | rdView[39:32] & {8{slot == 3'h4}};
  wire logic [7:0] statByte = {3'h0, bank_r, calcStat_r, dataStat_r};
  wire logic [31:0] rdWord = isAcc ? {24'h0, rdByte}
    : isStat ? {24'h0, statByte}
    : isCfg ? {24'h0, cfg_r}
    : isIst ? {30'h0, ist_r}
    : isMsk ? {30'h0, msk_r} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // write path: byte into the image, image shifted left with fill
  maca_acc_t wrImgNew;
  always_comb begin
    wrImgNew = wrImg_r;
    if (slot == 3'h4) begin
      wrImgNew[39:32] = pwdata[7:0];
    end else begin
      wrImgNew[slot[1:0] * 8 +: 8] = pwdata[7:0];
    end
  end
  wire maca_acc_t fillMask = ~(40'hffffffffff << inShift);
  wire maca_acc_t wrShifted = (wrImgNew << inShift) | (fillMask & {40{fillBit}});

  ////////////////////////////////////////////////////////////////////////////
  // bank handshake
  always_comb begin
    bank_nxt = bank_r;
    dataStat_nxt = dataStat_r;
    calcStat_nxt = calcStat_r;
    startNow = 1'b0;
    swapNow = 1'b0;
    if (engDone && calcStat_r == CS_BUSY) begin
      calcStat_nxt = CS_DONE;
    end
    if (rdAc4) begin
      dataStat_nxt = DS_EMPTY;
      if (calcStat_r == CS_DONE) begin
        bank_nxt = ~bank_r;
        dataStat_nxt = DS_DONE;
        calcStat_nxt = CS_EMPTY;
        swapNow = 1'b1;
      end
    end else if (wrAc4 && dataStat_r == DS_EMPTY) begin
      dataStat_nxt = DS_READY;
    end
    // a prepared calculation starts as soon as the compute side is free
    if (dataStat_nxt == DS_READY && calcStat_nxt == CS_EMPTY && engIdle && !swapNow) begin
      bank_nxt = ~bank_nxt;
      dataStat_nxt = DS_EMPTY;
      calcStat_nxt = CS_BUSY;
      startNow = 1'b1;
    end
    if (dataStat_nxt == DS_EMPTY && calcStat_nxt == CS_EMPTY) begin
      bank_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bank_r <= 1'b0;
      dataStat_r <= DS_EMPTY;
      calcStat_r <= CS_EMPTY;
      engStart_r <= 1'b0;
    end else if (cen) begin
      bank_r <= bank_nxt;
      dataStat_r <= dataStat_nxt;
      calcStat_r <= calcStat_nxt;
      engStart_r <= startNow;
    end
  end
  assign engStart = engStart_r;

  ////////////////////////////////////////////////////////////////////////////
  // accumulator banks, no reset
  always_ff @(posedge mclk) begin
    if (cen && wrAcc) begin
      wrImg_r <= wrImgNew;
      acc_r[bank_r] <= wrShifted;
    end
    if (cen && engDone && calcStat_r == CS_BUSY) begin
      acc_r[~bank_r] <= engResult;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // config, interrupts, read data
  wire logic [1:0] evt = {swapNow | startNow, engDone & (calcStat_r == CS_BUSY)};
  wire logic [1:0] istClr = (access & pwrite & isIst) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= `MACA_CFG_RESET;
      ist_r <= `MACA_IRQ_RESET;
      msk_r <= `MACA_IRQ_RESET;
      prdata_r <= 32'h0;
    end else if (cen) begin
      if (access && pwrite && isCfg) begin
        cfg_r <= pwdata[7:0];
      end
      if (access && pwrite && isMsk) begin
        msk_r <= pwdata[1:0];
      end
      ist_r <= (ist_r & ~istClr) | evt;
      if (setup && !pwrite) begin
        prdata_r <= rdWord;
      end
    end
  end
  assign prdata = prdata_r;
  assign irq = |(ist_r & msk_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  wire logic rdByte0Setup = setup & ~pwrite & (slot == 3'h0);

  sequence s_rdSetup0;
    rdByte0Setup && outShift == 3'h0;
  endsequence
  sequence s_accessFollows;
    psel && penable && cen;
  endsequence
  sequence s_rdSetup4;
    setup && !pwrite && slot == 3'h4 && dataStat_r != DS_EMPTY;
  endsequence

  property p_rdEmpties;
    @(posedge mclk) disable iff (!nrst)
      rdAc4 && calcStat_r != CS_DONE |=> dataStat_r == DS_EMPTY;
  endproperty
  a_rdEmpties: assert property (p_rdEmpties) else $error("top byte read did not empty data bank");

  property p_rdSwap;
    @(posedge mclk) disable iff (!nrst)
      rdAc4 && calcStat_r == CS_DONE |=> dataStat_r == DS_DONE && calcStat_r == CS_EMPTY && bank_r != $past(bank_r);
  endproperty
  a_rdSwap: assert property (p_rdSwap) else $error("top byte read with done result did not swap");

  property p_wrReady;
    @(posedge mclk) disable iff (!nrst)
      wrAc4 && dataStat_r == DS_EMPTY && !(calcStat_r == CS_EMPTY && engIdle) |=> dataStat_r == DS_READY;
  endproperty
  a_wrReady: assert property (p_wrReady) else $error("top byte write did not mark data ready");

  property p_wrStart;
    @(posedge mclk) disable iff (!nrst)
      wrAc4 && dataStat_r == DS_EMPTY && calcStat_r == CS_EMPTY && engIdle
      |=> engStart && calcStat_r == CS_BUSY && bank_r != $past(bank_r) ##1 !engStart;
  endproperty
  a_wrStart: assert property (p_wrStart) else $error("write did not start the engine");

  property p_noInvalid;
    @(posedge mclk) disable iff (!nrst)
      dataStat_r != 2'h2;
  endproperty
  a_noInvalid: assert property (p_noInvalid) else $error("data bank status invalid");

  property p_rdByte0;
    @(posedge mclk) disable iff (!nrst)
      s_rdSetup0 ##1 s_accessFollows |-> prdata == {24'h0, $past(dataAcc[7:0])};
  endproperty
  a_rdByte0: assert property (p_rdByte0) else $error("byte 0 read data wrong");

  property p_wrByte4;
    @(posedge mclk) disable iff (!nrst)
      wrAc4 && inShift == 3'h0 && !startNow && !swapNow |=> dataAcc[39:32] == $past(pwdata[7:0]);
  endproperty
  a_wrByte4: assert property (p_wrByte4) else $error("top byte write not stored");

  property p_doneLatch;
    @(posedge mclk) disable iff (!nrst)
      cen && engDone && calcStat_r == CS_BUSY |=> calcStat_r == CS_DONE && ist_r[`MACA_IRQ_DONE_BIT];
  endproperty
  a_doneLatch: assert property (p_doneLatch) else $error("engine completion not recorded");

  property p_wrByte0;
    @(posedge mclk) disable iff (!nrst)
      wrAcc && slot == 3'h0 && inShift == 3'h0 && !startNow |=> dataAcc[7:0] == $past(pwdata[7:0]);
  endproperty
  a_wrByte0: assert property (p_wrByte0) else $error("byte 0 write not stored");

  property p_wrByte3;
    @(posedge mclk) disable iff (!nrst)
      wrAcc && slot == 3'h3 && inShift == 3'h0 && !startNow |=> dataAcc[31:24] == $past(pwdata[7:0]);
  endproperty
  a_wrByte3: assert property (p_wrByte3) else $error("byte 3 write not stored");

  property p_rdSign;
    @(posedge mclk) disable iff (!nrst)
      s_rdSetup4 ##1 s_accessFollows |-> prdata[7] == $past(dataAcc[39]);
  endproperty
  a_rdSign: assert property (p_rdSign) else $error("top byte read lost the sign bit");

  property p_wrFill;
    @(posedge mclk) disable iff (!nrst)
      wrAcc && inShift != 3'h0 && !startNow |=> dataAcc[0] == $past(fillBit);
  endproperty
  a_wrFill: assert property (p_wrFill) else $error("write shift fill bit wrong");

  property p_startPulse;
    @(posedge mclk) disable iff (!nrst)
      engStart |=> !engStart;
  endproperty
  a_startPulse: assert property (p_startPulse) else $error("engine start longer than one cycle");
endmodule

// ### verification/maca_eng_model.sv
// stand-in for the multiply engine: fixed latency, result is the operand plus one
`timescale 1ns/1ps

module maca_eng_model #(parameter int LAT = 20) (
  input wire logic mclk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic busy, // holds the engine off
  input wire logic engStart, // start pulse
  input wire maca_pkg::maca_acc_t calcAcc, // operand
  output logic engIdle, // can accept work
  output logic engDone, // finish pulse
  output maca_pkg::maca_acc_t engResult // result
);
  import maca_pkg::*;
  int cnt_r;
  assign engIdle = (cnt_r == 0) && !busy;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 0;
      engDone <= 1'b0;
      engResult <= '0;
    end else begin
      cnt_r <= engStart ? LAT : ((cnt_r > 0) ? cnt_r - 1 : 0);
      engDone <= (cnt_r == 1);
      // result toggles outside its valid cycle
      engResult <= (cnt_r == 1) ? calcAcc + 40'h1 : ~engResult;
    end
  end
endmodule

// ### verification/tb.sv
// self-checking bench for the accumulator access block
`timescale 1ns/1ps
`include "maca_consts.svh"

module tb;
  import maca_pkg::*;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, busy = 1, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, engIdle, engDone, engStart, irq;
  maca_acc_t engResult, calcAcc, v, e;
  int num_errors = 0, check_count = 0, seed = 53905, n, m, f;
  logic [32:0] q[$];
  always #2.5 mclk = ~mclk;
  maca_access i_maca_access (.mclk(mclk), .nrst(nrst), .cen(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .engIdle(engIdle), .engDone(engDone), .engResult(engResult), .calcAcc(calcAcc), .engStart(engStart),
    .irq(irq));
  maca_eng_model i_maca_eng_model (.mclk(mclk), .nrst(nrst), .busy(busy), .engStart(engStart),
    .calcAcc(calcAcc), .engIdle(engIdle), .engDone(engDone), .engResult(engResult));
  //////////////////////////////////////////////////////////////////////////////
  task check(input logic [39:0] s, input logic [39:0] x);
    check_count++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    r = $random(seed);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {r[31:8], d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  // expected read data noted before the request, bit 32 enables the compare
  task rd(input logic [7:0] idx, input logic c, input logic [7:0] x);
    q.push_back({c, 24'h0, x});
    apb(1'b0, idx, 8'h00);
  endtask
  task wacc(input maca_acc_t a);
    for (int i = 0; i < 5; i++) wr(8'(`MACA_IDX_AC0 + i), a[8*i +: 8]);
  endtask
  task racc(input maca_acc_t a);
    for (int i = 0; i < 5; i++) rd(8'(`MACA_IDX_AC0 + i), 1'b1, a[8*i +: 8]);
  endtask
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      if (q[0][32]) check({8'h00, prdata}, {8'h00, q[0][31:0]});
      void'(q.pop_front());
    end
  end
  initial begin
    #100000;
    num_errors++;
    summarize;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    v = {8'($random(seed)), 32'($random(seed))};
    wacc(v);
    rd(`MACA_IDX_STAT, 1'b1, 8'h01);
    racc(v);
    rd(`MACA_IDX_STAT, 1'b1, 8'h00);
    $display("test byte access done");
    busy <= 1'b0;
    v = {8'($random(seed)), 32'($random(seed))};
    wacc(v);
    for (int i = 0; i < 50 && engStart !== 1'b1; i++) @(negedge mclk);
    check(40'(engStart), 40'h1);
    check(calcAcc, v);
    rd(`MACA_IDX_STAT, 1'b1, 8'h18);
    for (int i = 0; i < 50 && engDone !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
    check(40'(irq), 40'h0);
    rd(`MACA_IDX_IRQST, 1'b1, 8'h03);
    rd(`MACA_IDX_STAT, 1'b1, 8'h1c);
    wr(`MACA_IDX_IRQMSK, 8'h01);
    @(negedge mclk);
    check(40'(irq), 40'h1);
    rd(`MACA_IDX_AC4, 1'b0, 8'h00);
    rd(`MACA_IDX_STAT, 1'b1, 8'h03);
    racc(v + 40'h1);
    rd(`MACA_IDX_STAT, 1'b1, 8'h00);
    wr(`MACA_IDX_IRQST, 8'h03);
    @(negedge mclk);
    check(40'(irq), 40'h0);
    $display("test calculation done");
    busy <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      n = (k == 0) ? 0 : ($random(seed) & 7);
      m = (k == 0) ? 0 : ($random(seed) & 7);
      f = $random(seed) & 1;
      wr(`MACA_IDX_CFG, 8'(f * 64 + m * 8 + n));
      v = {8'($random(seed)), 32'($random(seed))};
      e = (v << n) | ((f != 0) ? (40'h1 << n) - 40'h1 : 40'h0);
      e = $signed(e) >>> m;
      wacc(v);
      racc(e);
    end
    wr(`MACA_IDX_CFG, 8'h00);
    $display("test shifts done");
    rd(8'hff, 1'b1, 8'h00);
    check(40'(err), 40'h1);
    $display("test unmapped done");
    summarize;
  end
endmodule
